// *** pkg/gpio_pkg.sv ***
// Constants and encodings for the nibble GPIO block.
// Assumes a single 40 MHz system clock and static option straps.
package gpio_pkg;
  localparam int unsigned NUM_PORTS  = 6;
  localparam int unsigned PORT_WIDTH = 4;
  localparam int unsigned NUM_PINS   = NUM_PORTS * PORT_WIDTH;
  localparam int unsigned CLK_HZ     = 40_000_000;

  // Pin modes, two bits per pin
  localparam logic [1:0] MODE_INPUT  = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_BIDIR  = 2'h2;

  // Bit 0 special function, two bits per port
  localparam logic [1:0] BIT0_GPIO  = 2'h0;
  localparam logic [1:0] BIT0_RESET = 2'h1;
  localparam logic [1:0] BIT0_IR    = 2'h2;

  // Shared pad position: port E bit 3
  localparam int unsigned SHARED_PAD_INDEX = 4 * PORT_WIDTH + 3;

  // Carrier divider: selectable IR carrier 31 kHz to 58 kHz
  localparam int unsigned IR_FREQ_LOW_HZ  = 31_000;
  localparam int unsigned IR_FREQ_HIGH_HZ = 58_000;
  localparam int unsigned IR_HALF_MAX     = (CLK_HZ / (2 * IR_FREQ_LOW_HZ));
  localparam int unsigned IR_HALF_MIN     = (CLK_HZ / (2 * IR_FREQ_HIGH_HZ));
  localparam int unsigned IR_DIV_WIDTH    = 10;
  localparam logic [9:0]  IR_HALF_RESET   = 10'h000;

  localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// *** logic/pin_sync.sv ***
// Two-stage synchroniser for a vector of pad inputs.
// Assumes pads are asynchronous to ref_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // pin_sync

// *** logic/ir_carrier.sv ***
// Infrared carrier generator: square wave, half period set in ref_clk cycles.
// Assumes half_period is static; zero is treated as one.
`timescale 1ns/1ps
module ir_carrier #(
  parameter int unsigned DIV_WIDTH = 10
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic [DIV_WIDTH-1:0] half_period,
  output logic                      carrier
);
  logic [DIV_WIDTH-1:0] count_q;
  logic [DIV_WIDTH-1:0] count_d;
  logic                 level_q;
  logic                 level_d;

  always_comb
  begin
    count_d = count_q + DIV_WIDTH'(1);
    level_d = level_q;
    if (count_d >= half_period)
    begin
      count_d = '0;
      level_d = ~level_q;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      count_q <= '0;
      level_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      level_q <= level_d;
    end
  end

  assign carrier = level_q;
endmodule // ir_carrier

// *** logic/nibble_gpio.sv ***
// Six nibble-wide GPIO ports with per-pin static options.
// Assumes options are strapped before reset release and held.
//
// Summary of operation
// - Twenty-four pins form ports A to F, four bits each.
// - Each pin is an input, an output or a bidirectional pin.
// - An input pin may enable its own pull-up.
// - An output pin starts after reset at its chosen initial level.
// - Each output pin selects normal drive or large sink.
// - A bidirectional pin with register bit 0 drives low and never high.
// - A bidirectional pin with register bit 1 releases the pad so reads see the outside level.
// - A bidirectional pin has either a pull-up or is open-drain.
// - A bidirectional pin may use large sink current when pulling low.
// - Bit 0 of any port can become an external reset input or an IR carrier output.
// - Reset pins have a selectable pull-up; IR pins have an initial level and a sink option.
// - One global weak or strong choice sets all enabled pull-ups.
// - Choosing the oscillator function on port E bit 3 removes its GPIO function.
// - With that pad as GPIO only the internal resistor oscillator may run.
// - The IR output has a selectable carrier frequency and polarity.
`timescale 1ns/1ps
module nibble_gpio #(
  parameter int unsigned NPINS = gpio_pkg::NUM_PINS,
  parameter int unsigned NPORT = gpio_pkg::NUM_PORTS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // Core side
  input  wire logic [NPINS-1:0]       port_wdata,
  input  wire logic [NPINS-1:0]       port_wstrobe,
  output logic      [NPINS-1:0]       port_rdata,
  output logic      [NPINS-1:0]       port_reg,
  // Static options and per-port IR data
  input  wire logic [2*NPINS-1:0]     pin_mode,
  input  wire logic [NPINS-1:0]       pull_up_en,
  input  wire logic [NPINS-1:0]       init_high,
  input  wire logic [NPINS-1:0]       large_sink,
  input  wire logic [2*NPORT-1:0]     bit0_function,
  input  wire logic                   pull_up_strong,
  input  wire logic                   shared_pad_is_osc,
  input  wire logic                   osc_external_resistor_osc_request,
  input  wire logic [9:0]             ir_half_period,
  input  wire logic                   ir_active_high,
  input  wire logic [NPORT-1:0]       ir_data,
  // Pads
  input  wire logic [NPINS-1:0]       pad_in,
  output logic      [NPINS-1:0]       pad_out,
  output logic      [NPINS-1:0]       pad_oe,
  output logic      [NPINS-1:0]       pad_pull_en,
  output logic                        pad_pull_strong,
  output logic      [NPINS-1:0]       pad_large_sink,
  // Special functions
  output logic                        external_reset_req,
  output logic                        external_resistor_osc
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] mode_of(input logic [2*NPINS-1:0] m, input int unsigned i);
    mode_of = m[2*i +: 2];
  endfunction

  function automatic logic [1:0] bit0_of(input logic [2*NPORT-1:0] f, input int unsigned p);
    bit0_of = f[2*p +: 2];
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [NPINS-1:0] pin_level;

  pin_sync #(.WIDTH(NPINS)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (pad_in),
    .sync_out (pin_level)
  );

  // ------------------------------------------------------------
  // IR carrier
  // ------------------------------------------------------------
  logic carrier;

  ir_carrier #(.DIV_WIDTH(gpio_pkg::IR_DIV_WIDTH)) u_ir (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .half_period (ir_half_period),
    .carrier     (carrier)
  );

  // ------------------------------------------------------------
  // Port data registers
  // ------------------------------------------------------------
  // Reset value cannot come from straps asynchronously; a flag loads
  // the initial levels on the first clock after release.
  logic             loaded_q;
  logic             loaded_d;
  logic [NPINS-1:0] data_q;
  logic [NPINS-1:0] data_d;

  always_comb
  begin
    loaded_d = 1'b1;
    data_d   = data_q;
    if (!loaded_q)
    begin
      data_d = init_high;
    end
    else
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        if (port_wstrobe[i])
        begin
          data_d[i] = port_wdata[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      loaded_q <= 1'b0;
      data_q   <= '0;
    end
    else
    begin
      loaded_q <= loaded_d;
      data_q   <= data_d;
    end
  end

  // Until loaded, present init_high so outputs honour the option at once
  logic [NPINS-1:0] eff_data;
  assign eff_data = loaded_q ? data_q : init_high;
  assign port_reg = data_q;

  // ------------------------------------------------------------
  // Pad control
  // ------------------------------------------------------------
  logic [NPINS-1:0] out_c;
  logic [NPINS-1:0] oe_c;
  logic [NPINS-1:0] pull_c;
  logic [NPINS-1:0] sink_c;
  logic [NPINS-1:0] rd_c;
  logic             rst_c;

  always_comb
  begin
    out_c = '0;
    oe_c  = '0;
    pull_c = '0;
    sink_c = '0;
    rd_c  = pin_level;
    rst_c = 1'b0;
    for (int i = 0; i < NPINS; i++)
    begin
      case (mode_of(pin_mode, i))
        gpio_pkg::MODE_INPUT:
        begin
          pull_c[i] = pull_up_en[i];
        end
        gpio_pkg::MODE_OUTPUT:
        begin
          out_c[i]  = eff_data[i];
          oe_c[i]   = 1'b1;
          sink_c[i] = large_sink[i];
        end
        gpio_pkg::MODE_BIDIR:
        begin
          out_c[i]  = 1'b0;
          oe_c[i]   = ~eff_data[i];
          pull_c[i] = pull_up_en[i] & eff_data[i];
          sink_c[i] = large_sink[i] & ~eff_data[i];
        end
        default:
        begin
          pull_c[i] = 1'b0;
        end
      endcase
    end
    for (int p = 0; p < NPORT; p++)
    begin
      case (bit0_of(bit0_function, p))
        gpio_pkg::BIT0_RESET:
        begin
          out_c[4*p]  = 1'b0;
          oe_c[4*p]   = 1'b0;
          sink_c[4*p] = 1'b0;
          pull_c[4*p] = pull_up_en[4*p];
          rst_c = rst_c | ~pin_level[4*p];
        end
        gpio_pkg::BIT0_IR:
        begin
          // Carrier gated by data; idle holds the initial level
          if (ir_data[p] == ir_active_high)
          begin
            out_c[4*p] = carrier;
          end
          else
          begin
            out_c[4*p] = init_high[4*p];
          end
          oe_c[4*p]   = 1'b1;
          sink_c[4*p] = large_sink[4*p];
          pull_c[4*p] = 1'b0;
        end
        default:
        begin
          rst_c = rst_c;
        end
      endcase
    end
    if (shared_pad_is_osc)
    begin
      out_c[gpio_pkg::SHARED_PAD_INDEX]  = 1'b0;
      oe_c[gpio_pkg::SHARED_PAD_INDEX]   = 1'b0;
      pull_c[gpio_pkg::SHARED_PAD_INDEX] = 1'b0;
      sink_c[gpio_pkg::SHARED_PAD_INDEX] = 1'b0;
      rd_c[gpio_pkg::SHARED_PAD_INDEX]   = 1'b0;
    end
  end

  // Data outputs registered; pads follow config one cycle later
  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] oe_q;
  logic [NPINS-1:0] pull_q;
  logic [NPINS-1:0] sink_q;
  logic [NPINS-1:0] rd_q;
  logic             rst_q;
  logic             strong_q;
  logic             extr_q;
  logic             extr_d;

  assign extr_d = shared_pad_is_osc & osc_external_resistor_osc_request;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      out_q    <= '0;
      oe_q     <= '0;
      pull_q   <= '0;
      sink_q   <= '0;
      rd_q     <= '0;
      rst_q    <= 1'b0;
      strong_q <= 1'b0;
      extr_q   <= 1'b0;
    end
    else
    begin
      out_q    <= out_c;
      oe_q     <= oe_c;
      pull_q   <= pull_c;
      sink_q   <= sink_c;
      rd_q     <= rd_c;
      rst_q    <= rst_c;
      strong_q <= pull_up_strong;
      extr_q   <= extr_d;
    end
  end

  assign pad_out               = out_q;
  assign pad_oe                = oe_q;
  assign pad_pull_en           = pull_q;
  assign pad_pull_strong       = strong_q;
  assign pad_large_sink        = sink_q;
  assign port_rdata            = rd_q;
  assign external_reset_req    = rst_q;
  assign external_resistor_osc = extr_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_bidir_never_high;
    @(posedge ref_clk) disable iff (reset)
    (loaded_q && mode_of(pin_mode, 4) == gpio_pkg::MODE_BIDIR
      && bit0_of(bit0_function, 1) == gpio_pkg::BIT0_GPIO) |=> !(pad_oe[4] && pad_out[4]);
  endproperty
  a_bidir_never_high: assert property (p_bidir_never_high) else $error("bidir pin drove high");

  property p_bidir_release;
    @(posedge ref_clk) disable iff (reset)
    (loaded_q && mode_of(pin_mode, 6) == gpio_pkg::MODE_BIDIR && data_q[6]) |=> !pad_oe[6];
  endproperty
  a_bidir_release: assert property (p_bidir_release) else $error("bidir pin not released");

  property p_output_follows;
    @(posedge ref_clk) disable iff (reset)
    (loaded_q && mode_of(pin_mode, 2) == gpio_pkg::MODE_OUTPUT) |=> (pad_oe[2] && pad_out[2] == $past(data_q[2]));
  endproperty
  a_output_follows: assert property (p_output_follows) else $error("output pin mismatch");

  property p_read_latency;
    @(posedge ref_clk) disable iff (reset)
    (!reset && !shared_pad_is_osc) |-> ##3 (port_rdata[9] == $past(pad_in[9], 3));
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read path latency wrong");

  property p_osc_pad_quiet;
    @(posedge ref_clk) disable iff (reset)
    shared_pad_is_osc |=> !pad_oe[gpio_pkg::SHARED_PAD_INDEX];
  endproperty
  a_osc_pad_quiet: assert property (p_osc_pad_quiet) else $error("osc pad driven");

  property p_external_resistor_osc_gated;
    @(posedge ref_clk) disable iff (reset)
    !shared_pad_is_osc |=> !external_resistor_osc;
  endproperty
  a_external_resistor_osc_gated: assert property (p_external_resistor_osc_gated) else $error("external resistor with pad as gpio");

  property p_strength;
    @(posedge ref_clk) disable iff (reset)
    !reset |=> pad_pull_strong == $past(pull_up_strong);
  endproperty
  a_strength: assert property (p_strength) else $error("pull strength mismatch");

  property p_input_pull;
    @(posedge ref_clk) disable iff (reset)
    (!reset && mode_of(pin_mode, 9) == gpio_pkg::MODE_INPUT)
      |=> (pad_pull_en[9] == $past(pull_up_en[9]) && !pad_oe[9]);
  endproperty
  a_input_pull: assert property (p_input_pull) else $error("input pull wrong");

  property p_init_level;
    @(posedge ref_clk) disable iff (reset)
    (!reset && !loaded_q && mode_of(pin_mode, 2) == gpio_pkg::MODE_OUTPUT) |=> pad_out[2] == $past(init_high[2]);
  endproperty
  a_init_level: assert property (p_init_level) else $error("initial level wrong");
endmodule // nibble_gpio

// *** verification/board_model.sv ***
// Board wiring model for the nibble GPIO pads.
// Assumes pad_oe high means the device drives the pad.
`timescale 1ns/1ps
module board_model (
  input  wire logic        ref_clk,
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe,
  input  wire logic [23:0] pad_pull_en,
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] ext_val,
  output logic      [23:0] pad_level
);
  logic [23:0] float_q = 24'h55_5555;
  // ----------------------------------------
  // Pad resolution
  // ----------------------------------------
  // Floating pads wander so a stale value never reads back
  always @(posedge ref_clk) float_q <= ~float_q;
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                     (~pad_oe & ~ext_en & pad_pull_en) | (~pad_oe & ~ext_en & ~pad_pull_en & float_q);
endmodule // board_model

// *** verification/nibble_gpio_tb.sv ***
// Self-checking bench for the nibble GPIO block.
// Assumes board_model resolves the pads back into pad_in.
`timescale 1ns/1ps
module nibble_gpio_tb;
  logic        ref_clk           = 1'b0;
  logic        reset             = 1'b1;
  logic [23:0] port_wdata        = 24'h00_0000;
  logic [23:0] port_wstrobe      = 24'h00_0000;
  logic [47:0] pin_mode          = {{4{gpio_pkg::MODE_OUTPUT}}, {4{gpio_pkg::MODE_BIDIR}},
                                    {8{gpio_pkg::MODE_INPUT}}, {4{gpio_pkg::MODE_BIDIR}}, {4{gpio_pkg::MODE_OUTPUT}}};
  logic [23:0] pull_up_en        = 24'h00_3A50;
  logic [23:0] init_high         = 24'h50_0005;
  logic [23:0] large_sink        = 24'h10_0036;
  logic [11:0] bit0_function     = {gpio_pkg::BIT0_IR, gpio_pkg::BIT0_GPIO, gpio_pkg::BIT0_RESET,
                                    gpio_pkg::BIT0_GPIO, gpio_pkg::BIT0_GPIO, gpio_pkg::BIT0_GPIO};
  logic        pull_up_strong    = 1'b1;
  logic        shared_pad_is_osc = 1'b0;
  logic        osc_external_resistor_osc_request = 1'b1;
  logic [9:0]  ir_half_period    = 10'h004;
  logic        ir_active_high    = 1'b1;
  logic [5:0]  ir_data           = 6'h00;
  logic [23:0] ext_en            = 24'h00_0000;
  logic [23:0] ext_val           = 24'h00_0000;
  logic [23:0] port_rdata, port_reg, pad_level, pad_out, pad_oe, pad_pull_en, pad_large_sink;
  logic        pad_pull_strong, external_reset_req, external_resistor_osc;
  int          fail_count        = 0;
  int          checked           = 0;
  int          cycles            = 0;

  nibble_gpio nibble_gpio_inst (.ref_clk(ref_clk), .reset(reset), .port_wdata(port_wdata),
    .port_wstrobe(port_wstrobe), .port_rdata(port_rdata), .port_reg(port_reg), .pin_mode(pin_mode),
    .pull_up_en(pull_up_en), .init_high(init_high), .large_sink(large_sink), .bit0_function(bit0_function),
    .pull_up_strong(pull_up_strong), .shared_pad_is_osc(shared_pad_is_osc),
    .osc_external_resistor_osc_request(osc_external_resistor_osc_request), .ir_half_period(ir_half_period), .ir_active_high(ir_active_high),
    .ir_data(ir_data), .pad_in(pad_level), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_strong(pad_pull_strong), .pad_large_sink(pad_large_sink),
    .external_reset_req(external_reset_req), .external_resistor_osc(external_resistor_osc));
  board_model board_model_inst (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_level));

  always #12.5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Runaway guard, far above the planned run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    tick(2);
    check(pad_oe, 24'h00_0000);
    @(posedge ref_clk);
    reset <= 1'b0;
    tick(3);
  endtask
  // Strobe is sampled at the edge after launch; calls chain back to back
  task automatic wr(input logic [23:0] m, input logic [23:0] d);
    @(posedge ref_clk);
    port_wdata <= d;
    port_wstrobe <= m;
  endtask
  task automatic idle();
    @(posedge ref_clk);
    port_wstrobe <= 24'h00_0000;
    tick(2);
  endtask
  task automatic count_ir(input int n, output int t);
    logic prev;
    prev = pad_out[20];
    t = 0;
    repeat (n)
    begin
      tick(1);
      if (pad_out[20] !== prev) t++;
      prev = pad_out[20];
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_init();
    check(port_reg, init_high);
    check(pad_oe[3:0], 4'hF);
    check(pad_out[3:0], 4'h5);
    check(pad_pull_strong, 1'b1);
    check(external_resistor_osc, 1'b0);
    check(pad_oe[11:8], 4'h0);
    check(pad_pull_en[11:8], 4'hA);
    check(pad_pull_en[15:12], 4'h3);
  endtask
  task automatic t_out();
    wr(24'h00_000F, 24'h00_000A);
    wr(24'h00_0F0F, 24'h00_0C03);
    idle();
    check(port_reg[11:0], 12'hC03);
    check(pad_out[3:0], 4'h3);
    check(pad_oe[11:8], 4'h0);
    check(pad_large_sink[3:0], 4'h6);
  endtask
  task automatic t_bidir();
    wr(24'h0F_00F0, 24'h0F_0050);
    idle();
    check(pad_oe[7:4], 4'hA);
    check(pad_out[7:4] & pad_oe[7:4], 4'h0);
    check(pad_pull_en[7:4], 4'h5);
    check(pad_large_sink[7:4], 4'h2);
    check(pad_oe[19:16], 4'h0);
    check(pad_pull_en[19:16], 4'h0);
    @(posedge ref_clk);
    ext_en <= 24'h00_0010;
    tick(4);
    check(port_rdata[7:4], 4'h4);
  endtask
  task automatic t_in();
    @(posedge ref_clk);
    ext_en <= 24'h00_0F00;
    ext_val <= 24'h00_0600;
    tick(4);
    check(port_rdata[11:8], 4'h6);
    ext_val <= 24'h00_0900;
    tick(2);
    check(port_rdata[11:8], 4'h6);
    tick(1);
    check(port_rdata[11:8], 4'h9);
  endtask
  task automatic t_ext_reset();
    @(posedge ref_clk);
    ext_en <= 24'h00_1000;
    ext_val <= 24'h00_0000;
    tick(5);
    check(external_reset_req, 1'b1);
    ext_en <= 24'h00_0000;
    tick(5);
    check(external_reset_req, 1'b0);
  endtask
  task automatic t_ir();
    int t;
    check({pad_oe[20], pad_out[20]}, 2'h3);
    check(pad_large_sink[20], 1'b1);
    @(posedge ref_clk);
    ir_data <= 6'h20;
    count_ir(80, t);
    check(t >= 18 && t <= 21, 1'b1);
  endtask
  task automatic t_osc();
    int t;
    @(posedge ref_clk);
    shared_pad_is_osc <= 1'b1;
    ir_active_high <= 1'b0;
    ext_en <= 24'h08_0000;
    ext_val <= 24'h08_0000;
    do_reset();
    tick(3);
    check(external_resistor_osc, 1'b1);
    check(pad_oe[19], 1'b0);
    check(port_rdata[19], 1'b0);
    count_ir(20, t);
    check(t, 32'h0000_0000);
    check(pad_out[20], 1'b1);
    @(posedge ref_clk);
    ir_data <= 6'h00;
    count_ir(40, t);
    check(t >= 8, 1'b1);
  endtask

  initial
  begin
    tick(1);
    check(pad_oe, 24'h00_0000);
    @(posedge ref_clk);
    reset <= 1'b0;
    tick(3);
    t_init();
    t_out();
    t_bidir();
    t_in();
    t_ext_reset();
    t_ir();
    t_osc();
    results();
  end
endmodule // nibble_gpio_tb
